// ==== hw/crl_agc_acc.sv ====
`timescale 1ns/10ps
`include "crl_defs.svh"
// Gain loop filter accumulator with its load multiplexer
module crl_agc_acc
#(
   parameter int ACC_W = 32
)
(
   input logic clk_sys,
   input logic rst_n,
   crl_agc_if.acc agc
);
   import crl_pkg::*;
   if (ACC_W < 16)
   begin : g_chk
      $error("ACC_W too narrow for the gain word");
   end
   typedef struct packed {
      logic [ACC_W-1:0] acc; // Accumulator
      logic [3:0] exponent; // Registered exponent
      logic [8:0] mantissa; // Registered mantissa
   } ag_state_t;
   ag_state_t s, next_s;
   logic [ACC_W-1:0] master; // Written value placed in the MSBs
   assign master = {agc.loadWord, {(ACC_W-11){1'b0}}};
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      if (agc.clear)
         next_s.acc = '0;
      else if (agc.loadStb)
         next_s.acc = master;
      else if (agc.update)
         next_s.acc = agc.limiter;
      // Top bits are the exponent, next seven the mantissa
      next_s.exponent = next_s.acc[ACC_W-1 -: `CRL_EXP_W];
      next_s.mantissa = {`CRL_MANT_LEAD,
         next_s.acc[ACC_W-1-`CRL_EXP_W -: `CRL_MANT_W]};
   end
   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
   assign agc.exponent = s.exponent;
   assign agc.mantissa = s.mantissa;
endmodule

// ==== hw/crl_agc_if.sv ====
`timescale 1ns/10ps
// Link between the control logic and the gain accumulator
interface crl_agc_if #(parameter int ACC_W = 32);
   logic loadStb; // One-cycle gain load strobe
   logic [10:0] loadWord; // Written exponent and mantissa
   logic clear; // Clears the accumulator
   logic update; // Take limiter output this cycle
   logic [ACC_W-1:0] limiter; // Limiter output
   logic [3:0] exponent; // Shift exponent
   logic [8:0] mantissa; // Mantissa with leading 01
   modport ctl (output loadStb, loadWord, clear, update, limiter,
      input exponent, mantissa);
   modport acc (input loadStb, loadWord, clear, update, limiter,
      output exponent, mantissa);
endinterface

// ==== hw/crl_defs.svh ====
`ifndef CRL_DEFS_SVH
`define CRL_DEFS_SVH
// ----------------------------------------
// Register word indices
// ----------------------------------------
`define CRL_ADDR_INIT 8'h19
`define CRL_ADDR_GAIN 8'h1A
`define CRL_ADDR_CTRL 8'h1B
`define CRL_ADDR_ISTAT 8'h1C
`define CRL_ADDR_IMASK 8'h1D
`define CRL_ADDR_PSTAT 8'h1E
`define CRL_ADDR_SSTAT 8'h1F
`define CRL_ADDR_DSTAT 8'h20
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CRL_CTRL_INHIBIT 15
`define CRL_GAIN_HI 15
`define CRL_GAIN_LO 5
`define CRL_EXP_W 4
`define CRL_MANT_W 7
`define CRL_MANT_LEAD 2'h1
`define CRL_IRQ_INIT 0
`define CRL_IRQ_GAIN 1
`define CRL_IRQ_FULL 2
`define CRL_FIFO_RD_PRESET 3'h7
`define CRL_FIFO_WR_PRESET 3'h0
`define CRL_SER_SHIFT_RELOAD 4'hF
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CRL_FE_RESET_CYCLES 10
`define CRL_BE_RESET_CYCLES 10
`endif

// ==== hw/crl_init_ctrl.sv ====
`timescale 1ns/10ps
`include "crl_defs.svh"
module crl_init_ctrl
#(
   parameter int DISC_W = 5,
   parameter int CORDIC_ITER = 16,
   parameter int FIFO_DEPTH = 8,
   parameter logic [15:0] SNAP_INTERVAL = 16'h0100,
   parameter logic [7:0] SER_WORDS = 8'h02,
   parameter logic [7:0] SER_SYNC = 8'h01,
   parameter logic [7:0] SER_DIV = 8'h03,
   parameter int ACC_W = 32
)
(
   input logic clk_sys,
   input logic rst_n,
   input crl_pkg::crl_addr_t regAddr,
   input crl_pkg::crl_word_t regWdata,
   input logic regWr,
   input logic regRd,
   output crl_pkg::crl_word_t regRdata,
   input logic discSample,
   input logic discCompute,
   input logic cordicStart,
   input logic fifoPush,
   input logic fifoPop,
   input logic snapTick,
   input logic snapRead,
   input logic serTick,
   input logic agcUpdate,
   input logic [ACC_W-1:0] agcLimiter,
   output logic feInit,
   output logic beInit,
   output logic fifoReadStrobe,
   output logic dataReadyInterrupt,
   output logic fifoEmpty,
   output logic fifoFull,
   output logic [DISC_W-1:0] discCoefAddr,
   output logic cordicBusy,
   output logic [3:0] agcExponent,
   output logic [8:0] agcMantissa,
   output logic irq
);
   import crl_pkg::*;
   // Iteration counter width, counts 0 to CORDIC_ITER-1
   localparam int CIW = $clog2(CORDIC_ITER);
   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (FIFO_DEPTH != 8 || DISC_W < 1 || DISC_W > 8 || CORDIC_ITER < 2
      || CORDIC_ITER > 256)
   begin : g_chk
      $error("Unsupported parameter values");
   end
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [DISC_W-1:0] discWr; // Sample write pointer
      logic [DISC_W-1:0] discRd; // Sample read pointer
      logic [DISC_W-1:0] discCoef; // Coefficient read address
      logic [CIW-1:0] cordicIter; // Iteration counter
      logic cordicBusy; // Computation in progress
      crl_fifo_dec_t fifoDec; // FIFO control decoder
      logic [2:0] fifoWr; // FIFO write address
      logic [2:0] fifoRd; // FIFO read address
      logic [3:0] fifoDepth; // Words held
      logic fifoEmpty; // Empty indication
      logic fifoFull; // Full indication
      logic fifoRdStb; // Read strobe pulse
      logic dataReady; // Data ready interrupt
      logic [3:0] snapGroup; // Snapshot group number
      logic [15:0] snapIntv; // Snapshot interval counter
      logic [2:0] snapWr; // Snapshot write address
      logic [2:0] snapRd; // Snapshot read address
      logic [3:0] serShift; // Bit shift counter
      logic [7:0] serWords; // Word count counter
      logic [7:0] serSync; // Early/late sync counter
      logic [7:0] serDiv; // Serial clock divider
      logic agcInhibit; // Keeps accumulator on init
      logic [2:0] irqStat; // Sticky event bits
      logic [2:0] irqMask; // Event enables
      logic irq; // Interrupt output
      crl_word_t rdData; // Read data
      logic initReq; // Init trigger pulse
      logic gainStb; // Gain load strobe
      logic [15:0] gainWord; // Written gain word
      logic beWas; // Back-end pulse last cycle
   } ic_state_t;
   ic_state_t s, next_s;
   // Event strobes for the sticky status bits
   logic fullEvt; // FIFO became full
   logic initDone; // Back-end pulse ended
   logic [2:0] irqClr; // Write-one-to-clear bits
   // Carries load, clear and limiter to the accumulator
   crl_agc_if #(.ACC_W(ACC_W)) agcLink();
   // ----------------------------------------
   // Reset pulses
   // ----------------------------------------
   // Both widths count clk_sys cycles; a new write restarts them
   crl_pulse_gen #(.LEN(`CRL_FE_RESET_CYCLES)) u_fe_pulse
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .trigger(s.initReq),
      .active(feInit)
   );
   // Back-end pulse holds every stage at its start values, the gain accumulator only while inhibit is off
   crl_pulse_gen #(.LEN(`CRL_BE_RESET_CYCLES)) u_be_pulse
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .trigger(s.initReq),
      .active(beInit)
   );
   // ----------------------------------------
   // Gain accumulator
   // ----------------------------------------
   assign agcLink.loadStb = s.gainStb;
   assign agcLink.loadWord = s.gainWord[`CRL_GAIN_HI:`CRL_GAIN_LO];
   // Clear wins over a load while the back-end pulse runs and inhibit is off
   assign agcLink.clear = beInit & ~s.agcInhibit;
   assign agcLink.update = agcUpdate;
   assign agcLink.limiter = agcLimiter;
   crl_agc_acc #(.ACC_W(ACC_W)) u_agc
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .agc(agcLink.acc)
   );
   // Exponent and mantissa already leave a flip-flop
   assign agcExponent = agcLink.exponent;
   assign agcMantissa = agcLink.mantissa;
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      // Strobes last one cycle unless set again below
      next_s.initReq = 1'b0;
      next_s.gainStb = 1'b0;
      next_s.fifoRdStb = 1'b0;
      next_s.rdData = '0;
      next_s.beWas = beInit;
      fullEvt = 1'b0;
      // Falling edge of the back-end pulse marks init done
      initDone = s.beWas & ~beInit;
      irqClr = '0;
      // Register writes
      if (regWr)
      begin
         case (regAddr)
            `CRL_ADDR_INIT: next_s.initReq = 1'b1;
            `CRL_ADDR_GAIN:
            begin
               next_s.gainStb = 1'b1;
               next_s.gainWord = regWdata[15:0];
            end
            // Control bit 15 keeps the accumulator through an init
            `CRL_ADDR_CTRL: next_s.agcInhibit = regWdata[`CRL_CTRL_INHIBIT];
            `CRL_ADDR_ISTAT: irqClr = regWdata[2:0];
            `CRL_ADDR_IMASK: next_s.irqMask = regWdata[2:0];
            default: ; // Unmapped writes are dropped
         endcase
      end
      // Back-end stages held at their start values
      if (beInit)
      begin
         next_s.discWr = '0;
         next_s.discRd = '0;
         next_s.discCoef = '0;
         next_s.cordicIter = '0;
         next_s.cordicBusy = 1'b0;
         next_s.fifoDec = FD_IDLE;
         next_s.fifoWr = `CRL_FIFO_WR_PRESET;
         next_s.fifoRd = `CRL_FIFO_RD_PRESET;
         next_s.dataReady = 1'b0;
         next_s.fifoDepth = '0;
         next_s.fifoFull = 1'b0;
         next_s.fifoEmpty = 1'b1;
         next_s.snapGroup = '0;
         next_s.snapIntv = SNAP_INTERVAL;
         next_s.snapWr = '0;
         next_s.snapRd = '0;
         next_s.serShift = `CRL_SER_SHIFT_RELOAD;
         next_s.serWords = SER_WORDS;
         next_s.serSync = SER_SYNC;
         next_s.serDiv = SER_DIV;
      end
      else
      begin
         // Discriminator pointers
         if (discSample)
            next_s.discWr = s.discWr + 1'b1;
         if (discCompute)
         begin
            next_s.discRd = s.discRd + 1'b1;
            next_s.discCoef = s.discCoef + 1'b1;
         end
         // Coordinate converter iterations
         if (s.cordicBusy)
         begin
            if (s.cordicIter == CIW'(CORDIC_ITER - 1))
               next_s.cordicBusy = 1'b0;
            else
               next_s.cordicIter = s.cordicIter + 1'b1;
         end
         // A start while busy is ignored
         else if (cordicStart)
         begin
            next_s.cordicBusy = 1'b1;
            next_s.cordicIter = '0;
         end
         // FIFO control, push before pop, full push and empty pop ignored
         next_s.fifoDec = FD_IDLE;
         if (fifoPush && !s.fifoFull)
         begin
            next_s.fifoDec = FD_PUSH;
            next_s.fifoWr = s.fifoWr + 1'b1;
            next_s.fifoDepth = s.fifoDepth + 1'b1;
            next_s.dataReady = 1'b1;
         end
         else if (fifoPop && !s.fifoEmpty)
         begin
            next_s.fifoDec = FD_POP;
            next_s.fifoRd = s.fifoRd + 1'b1;
            next_s.fifoDepth = s.fifoDepth - 1'b1;
            next_s.fifoRdStb = 1'b1;
            // Last word leaving drops the data ready level
            if (s.fifoDepth == 4'h1)
               next_s.dataReady = 1'b0;
         end
         next_s.fifoEmpty = (next_s.fifoDepth == '0);
         next_s.fifoFull = (next_s.fifoDepth == 4'(FIFO_DEPTH));
         // Rising edge of full feeds status bit 2
         fullEvt = next_s.fifoFull & ~s.fifoFull;
         // Snapshot interval and addresses
         if (snapTick)
         begin
            if (s.snapIntv == '0)
            begin
               next_s.snapIntv = SNAP_INTERVAL;
               next_s.snapGroup = s.snapGroup + 1'b1;
               next_s.snapWr = s.snapWr + 1'b1;
            end
            else
               next_s.snapIntv = s.snapIntv - 1'b1;
         end
         // Read address never passes the write address
         if (snapRead && s.snapRd != s.snapWr)
            next_s.snapRd = s.snapRd + 1'b1;
         // Serial output counters
         if (serTick)
         begin
            if (s.serDiv == '0)
            begin
               next_s.serDiv = SER_DIV;
               if (s.serSync != '0)
                  next_s.serSync = s.serSync - 1'b1;
               if (s.serShift == '0)
               begin
                  next_s.serShift = `CRL_SER_SHIFT_RELOAD;
                  // Word count wraps back to its reload value
                  next_s.serWords = (s.serWords == '0) ? SER_WORDS
                     : s.serWords - 1'b1;
               end
               else
                  next_s.serShift = s.serShift - 1'b1;
            end
            else
               next_s.serDiv = s.serDiv - 1'b1;
         end
      end
      // Status bits: 0 init done, 1 gain loaded, 2 FIFO full
      // Sticky events, a new event wins over its clear
      next_s.irqStat = (s.irqStat & ~irqClr) | {fullEvt, s.gainStb, initDone};
      next_s.irq = |(next_s.irqStat & next_s.irqMask);
      // Register reads, answered in the next cycle
      if (regRd)
      begin
         case (regAddr)
            `CRL_ADDR_CTRL: next_s.rdData[`CRL_CTRL_INHIBIT] = s.agcInhibit;
            `CRL_ADDR_ISTAT: next_s.rdData[2:0] = s.irqStat;
            `CRL_ADDR_IMASK: next_s.rdData[2:0] = s.irqMask;
            // Bits 27:26 show the FIFO decoder state
            `CRL_ADDR_PSTAT: next_s.rdData = {4'h0, s.fifoDec, feInit, beInit,
               s.snapRd, s.snapWr, s.snapGroup, s.cordicBusy,
               s.dataReady, s.fifoFull, s.fifoEmpty, s.fifoDepth,
               s.fifoRd, s.fifoWr};
            `CRL_ADDR_SSTAT: next_s.rdData = {4'h0, s.serDiv, s.serSync,
               s.serWords, s.serShift};
            `CRL_ADDR_DSTAT: next_s.rdData = {8'(s.cordicIter),
               8'(s.discCoef), 8'(s.discRd), 8'(s.discWr)};
            default: next_s.rdData = '0; // Write-only and unmapped read zero
         endcase
      end
   end
   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         // Counters that reload start at their reload values
         s.fifoRd <= `CRL_FIFO_RD_PRESET;
         s.fifoEmpty <= 1'b1;
         s.snapIntv <= SNAP_INTERVAL;
         s.serShift <= `CRL_SER_SHIFT_RELOAD;
         s.serWords <= SER_WORDS;
         s.serSync <= SER_SYNC;
         s.serDiv <= SER_DIV;
      end
      else
         s <= next_s;
   end
   // Outputs straight from the state register
   assign regRdata = s.rdData;
   assign fifoReadStrobe = s.fifoRdStb;
   assign dataReadyInterrupt = s.dataReady;
   assign fifoEmpty = s.fifoEmpty;
   assign fifoFull = s.fifoFull;
   assign discCoefAddr = s.discCoef;
   assign cordicBusy = s.cordicBusy;
   // Level interrupt follows the masked sticky bits
   assign irq = s.irq;
endmodule

// ==== hw/crl_pkg.sv ====
package crl_pkg;
   // Register bus data word
   typedef logic [31:0] crl_word_t;
   // Register bus word index
   typedef logic [7:0] crl_addr_t;
   // Output FIFO control decoder states
   typedef enum logic [1:0] {FD_IDLE, FD_PUSH, FD_POP} crl_fifo_dec_t;
endpackage

// ==== hw/crl_pulse_gen.sv ====
`timescale 1ns/10ps
// Stretches a one-cycle trigger into a pulse LEN cycles wide
module crl_pulse_gen
#(
   parameter int LEN = 10
)
(
   input logic clk_sys,
   input logic rst_n,
   input logic trigger,
   output logic active
);
   import crl_pkg::*;
   localparam int CW = $clog2(LEN + 1);
   if (LEN < 1)
   begin : g_chk
      $error("LEN must be at least one");
   end
   typedef struct packed {
      logic [CW-1:0] cnt; // Cycles left in the pulse
      logic active; // Pulse output
   } pg_state_t;
   pg_state_t s, next_s;
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      if (trigger)
         next_s.cnt = CW'(LEN); // A new trigger restarts the width
      else if (s.cnt != '0)
         next_s.cnt = s.cnt - 1'b1;
      next_s.active = (next_s.cnt != '0);
   end
   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
   assign active = s.active;
endmodule

// ==== sim/crl_host_model.sv ====
`timescale 1ns/10ps
`include "crl_defs.svh"
// ----
// Host processor writing and reading control words
// ----
module crl_host_model
(
   input logic clk_sys,
   output crl_pkg::crl_addr_t regAddr,
   output crl_pkg::crl_word_t regWdata,
   output logic regWr,
   output logic regRd,
   input crl_pkg::crl_word_t regRdata
);
   import crl_pkg::*;
   // Idle bus at time zero
   initial
   begin
      regAddr = 8'h00;
      regWdata = 32'h0000_0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // One-cycle write; gain words carry junk above bit 15
   task automatic wr(input crl_addr_t a, input crl_word_t d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= (a == `CRL_ADDR_GAIN) ? {~d[31:16], d[15:0]} : d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regWdata <= ~d;
   endtask
   // One-cycle read; data taken in the following cycle
   task automatic rd(input crl_addr_t a, output crl_word_t d);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask
endmodule

// ==== sim/crl_init_ctrl_properties.sv ====
`timescale 1ns/10ps
`include "crl_defs.svh"
// ----
// Port checks for the init control
// ----
module crl_init_ctrl_properties
#(
   parameter int DISC_W = 5
)
(
   input logic clk_sys,
   input logic rst_n,
   input crl_pkg::crl_addr_t regAddr,
   input crl_pkg::crl_word_t regWdata,
   input logic regWr,
   input logic fifoPush,
   input logic fifoPop,
   input logic feInit,
   input logic beInit,
   input logic fifoReadStrobe,
   input logic dataReadyInterrupt,
   input logic fifoEmpty,
   input logic fifoFull,
   input logic [DISC_W-1:0] discCoefAddr,
   input logic cordicBusy,
   input logic [3:0] agcExponent,
   input logic [8:0] agcMantissa
);
   import crl_pkg::*;
   logic [3:0] sinceInit; // Cycles since the last init write
   logic [3:0] gainExp; // Exponent field on the bus
   logic [6:0] gainMant; // Mantissa field on the bus
   logic initWr; // Init write seen
   logic gainWr; // Gain write seen
   assign gainExp = regWdata[15:12];
   assign gainMant = regWdata[11:5];
   assign initWr = regWr && regAddr == `CRL_ADDR_INIT;
   assign gainWr = regWr && regAddr == `CRL_ADDR_GAIN;
   // Saturating distance from the last init write
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sinceInit <= 4'hF;
      else if (initWr)
         sinceInit <= 4'h0;
      else if (sinceInit != 4'hF)
         sinceInit <= sinceInit + 4'h1;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ----
   // Assertions
   // ----
   a_init_rise: assert property (initWr && !beInit |=> !beInit ##1 beInit [*8])
      else $error("back-end reset missing after init write");
   a_be_width: assert property (sinceInit != 4'h0 |-> beInit == (sinceInit <= 4'hA))
      else $error("back-end reset width wrong");
   a_fe_width: assert property (sinceInit != 4'h0 |-> feInit == (sinceInit <= 4'hA))
      else $error("front-end reset width wrong");
   a_fifo_init: assert property (beInit && $past(beInit) |-> fifoEmpty && !fifoFull
      && !dataReadyInterrupt && !fifoReadStrobe)
      else $error("fifo flags not at start during init");
   a_stage_init: assert property (beInit && $past(beInit) |-> !cordicBusy
      && discCoefAddr == '0)
      else $error("stage counters not at start during init");
   a_gain_load: assert property ((gainWr && !beInit) ##1 !beInit |=>
      agcExponent == $past(gainExp, 2) && agcMantissa[6:0] == $past(gainMant, 2))
      else $error("gain word not loaded");
   a_mant_lead: assert property ($past(rst_n) |-> agcMantissa[8:7] == 2'h1)
      else $error("mantissa lead bits wrong");
   // Outside init, a pop on a non-empty FIFO is taken unless a push into a non-full FIFO wins that cycle
   a_pop_strobe: assert property (fifoReadStrobe |-> $past(fifoPop) && !$past(fifoEmpty)
      && !($past(fifoPush) && !$past(fifoFull)))
      else $error("read strobe without accepted pop");
   // Main scenarios
   c_init: cover property (initWr);
   c_gain: cover property (gainWr);
   c_full: cover property ($rose(fifoFull));
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`include "crl_defs.svh"
// ----
// Testbench for init pulse and gain load
// ----
module tb;
   import crl_pkg::*;
   typedef struct packed {crl_word_t w; logic [3:0] e; logic [8:0] m;} crl_row_t;
   // Gain words beside the exponent and mantissa they give
   crl_row_t rows [3] = '{'{32'h0000_A5E0, 4'hA, 9'h0AF}, '{32'hFFFF_001F, 4'h0, 9'h080},
      '{32'h1234_FFFF, 4'hF, 9'h0FF}};
   logic clk_sys = 1'b0; // 50 MHz clock
   logic rst_n = 1'b0; // Reset, active low
   crl_addr_t regAddr; // Bus address
   crl_word_t regWdata, regRdata, rdv; // Bus data and last read
   logic regWr, regRd; // Bus strobes
   logic [8:0] stim = 9'h000; // Pipeline event pulses
   logic discSample, discCompute, cordicStart, fifoPush, fifoPop;
   logic snapTick, snapRead, serTick, agcUpdate;
   logic [31:0] agcLimiter = 32'h3000_0000; // Fixed limiter output
   logic feInit, beInit, fifoReadStrobe, dataReadyInterrupt;
   logic fifoEmpty, fifoFull, cordicBusy, irq;
   logic [4:0] discCoefAddr;
   logic [3:0] agcExponent;
   logic [8:0] agcMantissa;
   int errTotal = 0; // Mismatches
   int comparisons = 0; // Comparisons made
   int beCount = 0; // Cycles with both resets high
   assign {discSample, discCompute, cordicStart, fifoPush, fifoPop, snapTick, snapRead, serTick,
      agcUpdate} = stim;
   always #10 clk_sys = ~clk_sys;
   // Measure the init pulse
   always @(posedge clk_sys)
      if (feInit === 1'b1 && beInit === 1'b1)
         beCount <= beCount + 1;
   crl_init_ctrl #(.SNAP_INTERVAL(16'h0004)) u_crl_init_ctrl (.*);
   crl_host_model u_crl_host_model (.*);
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Pulse one event input k times
   task automatic pulse(input int i, input int k);
      repeat (k)
      begin
         @(posedge clk_sys);
         stim[i] <= 1'b1;
         @(posedge clk_sys);
         stim[i] <= 1'b0;
      end
      #1;
   endtask
   // Verdict
   task automatic endOfTest();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      errTotal++;
      endOfTest();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      u_crl_host_model.rd(`CRL_ADDR_INIT, rdv);
      chk("init word", rdv, 32'h0);
      u_crl_host_model.rd(8'h40, rdv);
      chk("unmapped word", rdv, 32'h0);
      foreach (rows[i])
      begin
         u_crl_host_model.wr(`CRL_ADDR_GAIN, rows[i].w);
         @(posedge clk_sys);
         #1;
         chk("exponent", 32'(agcExponent), 32'(rows[i].e));
         chk("mantissa", 32'(agcMantissa), 32'(rows[i].m));
      end
      pulse(0, 1);
      chk("limiter exponent", 32'(agcExponent), 32'h3);
      // Stir every stage, then init with the converter busy
      u_crl_host_model.wr(`CRL_ADDR_IMASK, 32'h1);
      pulse(5, 8);
      chk("fifo full", 32'(fifoFull), 32'h1);
      pulse(4, 1);
      chk("read strobe", 32'(fifoReadStrobe), 32'h1);
      pulse(8, 3);
      pulse(7, 2);
      chk("coef address", 32'(discCoefAddr), 32'h2);
      pulse(3, 5);
      pulse(1, 5);
      pulse(6, 1);
      chk("converter busy", 32'(cordicBusy), 32'h1);
      chk("no pulse yet", 32'(beCount), 32'h0);
      u_crl_host_model.wr(`CRL_ADDR_INIT, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk_sys);
      u_crl_host_model.rd(`CRL_ADDR_PSTAT, rdv);
      chk("pipe status", rdv, 32'h0300_0438);
      u_crl_host_model.rd(`CRL_ADDR_DSTAT, rdv);
      chk("disc status", rdv, 32'h0);
      u_crl_host_model.rd(`CRL_ADDR_SSTAT, rdv);
      chk("serial status", rdv, 32'h0030_102F);
      repeat (8) @(posedge clk_sys);
      #1;
      chk("pulse width", 32'(beCount), 32'hA);
      chk("front end low", 32'(feInit), 32'h0);
      chk("cleared exponent", 32'(agcExponent), 32'h0);
      chk("init irq", 32'(irq), 32'h1);
      u_crl_host_model.rd(`CRL_ADDR_ISTAT, rdv);
      chk("irq status", rdv, 32'h7);
      u_crl_host_model.rd(`CRL_ADDR_IMASK, rdv);
      chk("irq mask", rdv, 32'h1);
      u_crl_host_model.wr(`CRL_ADDR_ISTAT, 32'h7);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("irq cleared", 32'(irq), 32'h0);
      // Inhibit keeps the accumulator through an init
      u_crl_host_model.wr(`CRL_ADDR_GAIN, 32'h0000_A5E0);
      u_crl_host_model.wr(`CRL_ADDR_CTRL, 32'h1 << `CRL_CTRL_INHIBIT);
      u_crl_host_model.rd(`CRL_ADDR_CTRL, rdv);
      chk("inhibit bit", rdv, 32'h0000_8000);
      u_crl_host_model.wr(`CRL_ADDR_INIT, 32'h0);
      repeat (14) @(posedge clk_sys);
      #1;
      chk("kept exponent", 32'(agcExponent), 32'hA);
      // Reset in mid-run
      pulse(5, 2);
      rst_n <= 1'b0;
      #5;
      chk("empty in reset", 32'(fifoEmpty), 32'h1);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      pulse(5, 1);
      chk("ready after reset", 32'(dataReadyInterrupt), 32'h1);
      endOfTest();
   end
endmodule
bind crl_init_ctrl crl_init_ctrl_properties #(.DISC_W(DISC_W)) u_crl_init_ctrl_properties (.*);
